// ==== include/lbc_defs.svh ====
// register offsets, field positions and reset values of the display irq / base channel bank
`ifndef LBC_DEFS_SVH
`define LBC_DEFS_SVH

// byte addresses
`define LBC_TOP_IRQ_ENABLE      32'hf803802c
`define LBC_TOP_IRQ_DISABLE     32'hf8038030
`define LBC_TOP_IRQ_MASK        32'hf8038034
`define LBC_TOP_IRQ_STATUS      32'hf8038038
`define LBC_BASE_CH_ENABLE      32'hf8038040
`define LBC_BASE_CH_DISABLE     32'hf8038044
`define LBC_BASE_CH_STATE       32'hf8038048
`define LBC_BASE_IRQ_ENABLE     32'hf803804c
`define LBC_BASE_IRQ_DISABLE    32'hf8038050
`define LBC_BASE_IRQ_MASK       32'hf8038054
`define LBC_BASE_IRQ_STATUS     32'hf8038058

// top-level status and mask fields
`define LBC_TOP_SOF_BIT         0
`define LBC_TOP_TIMING_OFF_BIT  1
`define LBC_TOP_POWER_SEQ_BIT   2
`define LBC_TOP_UNDERFLOW_BIT   4
`define LBC_TOP_BASE_BIT        8
`define LBC_TOP_OVERLAY_ONE_BIT 9
`define LBC_TOP_HIGH_END_BIT    10
`define LBC_TOP_CURSOR_BIT      11
`define LBC_TOP_VALID           12'hf17
`define LBC_TOP_RAW_VALID       12'h017

// base channel enable / disable / state fields
`define LBC_CH_ON_BIT           0
`define LBC_CH_UPDATE_BIT       1
`define LBC_CH_QUEUE_BIT        2
`define LBC_CH_STOP_BIT         0
`define LBC_CH_ABORT_BIT        8

// base-layer interrupt sources
`define LBC_BASE_DMA_END_BIT    2
`define LBC_BASE_DESC_LOADED_BIT 3
`define LBC_BASE_HEAD_BIT       4
`define LBC_BASE_LIST_END_BIT   5
`define LBC_BASE_OVERFLOW_BIT   6
`define LBC_BASE_VALID          7'h7c

// reset values
`define LBC_TOP_MASK_RESET      12'h000
`define LBC_TOP_FLAGS_RESET     12'h000
`define LBC_BASE_MASK_RESET     7'h00
`define LBC_BASE_FLAGS_RESET    7'h00

`endif

// ==== include/lbc_pkg.sv ====
// types shared by the display irq / base channel bank
package lbc_pkg;

    typedef enum logic [1:0] {
        LBC_CH_OFF      = 2'b00,
        LBC_CH_ON       = 2'b01,
        LBC_CH_STOPPING = 2'b10
    } lbc_chan_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } lbc_req_s;

    // event pulses and levels from the timing, output and layer engines
    typedef struct packed {
        logic       start_of_frame;
        logic       frame_done;
        logic       timing_off_done;
        logic       power_sequence_done;
        logic       output_underflow;
        logic [6:0] base_source;
        logic       head_added;
        logic       overlay_one_pending;
        logic       high_end_overlay_pending;
        logic       cursor_pending;
    } lbc_evt_s;

    typedef struct packed {
        lbc_chan_e   chan;
        logic        update_pend;
        logic        queue_pend;
        logic [11:0] top_mask;
        logic [11:0] top_flags;
        logic [6:0]  base_mask;
        logic [6:0]  base_flags;
        logic        apply;
        logic        abort;
        logic [31:0] rdata;
    } lbc_state_s;

endpackage

// ==== verilog/lbc_top.sv ====
// display controller irq status/mask and base-layer channel control register bank
`timescale 1ns/1ns
`include "lbc_defs.svh"

module lbc_top
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // register port
    input  wire lbc_pkg::lbc_req_s bus_req,
    output logic [31:0]          rd_data,
    // engine events
    input  wire lbc_pkg::lbc_evt_s evt,
    // base channel control
    output logic                 channel_on,
    output logic                 attribute_apply,
    output logic                 head_queue_request,
    output logic                 channel_abort,
    // interrupt
    output logic                 irq
);

    // field masks as vectors so the per-bit slices can index them
    localparam logic [11:0] TOP_VALID     = `LBC_TOP_VALID;
    localparam logic [11:0] TOP_RAW_VALID = `LBC_TOP_RAW_VALID;
    localparam logic [6:0]  BASE_VALID    = `LBC_BASE_VALID;

    // one comparator slot per mapped register, shared by reads and writes
    localparam logic [31:0] REG_ADDR [11] = '{
        `LBC_TOP_IRQ_ENABLE,
        `LBC_TOP_IRQ_DISABLE,
        `LBC_TOP_IRQ_MASK,
        `LBC_TOP_IRQ_STATUS,
        `LBC_BASE_CH_ENABLE,
        `LBC_BASE_CH_DISABLE,
        `LBC_BASE_CH_STATE,
        `LBC_BASE_IRQ_ENABLE,
        `LBC_BASE_IRQ_DISABLE,
        `LBC_BASE_IRQ_MASK,
        `LBC_BASE_IRQ_STATUS
    };
    localparam int          SLOT_TOP_EN      = 0;
    localparam int          SLOT_TOP_CLR     = 1;
    localparam int          SLOT_TOP_STATUS  = 3;
    localparam int          SLOT_CH_EN       = 4;
    localparam int          SLOT_CH_STOP     = 5;
    localparam int          SLOT_BASE_EN     = 7;
    localparam int          SLOT_BASE_CLR    = 8;
    localparam int          SLOT_BASE_STATUS = 10;

    lbc_pkg::lbc_state_s s_reg;
    lbc_pkg::lbc_state_s s_next;
    logic                wr_hit_top_en;
    logic                wr_hit_top_clr;
    logic                wr_hit_ch_en;
    logic                wr_hit_ch_stop;
    logic                wr_hit_base_en;
    logic                wr_hit_base_clr;
    logic                rd_hit_top_isr;
    logic                rd_hit_base_isr;
    logic                base_summary;
    logic [11:0]         top_status;
    logic [31:0]         rd_value;
    logic [10:0]         addr_hit;
    logic [11:0]         top_events;
    logic [11:0]         top_mask_upd;
    logic [11:0]         top_flags_upd;
    logic [6:0]          base_mask_upd;
    logic [6:0]          base_flags_upd;

    genvar ga;
    generate
        for (ga = 0; ga < 11; ga++)
        begin : g_addr_slot
            assign addr_hit[ga] = (bus_req.addr == REG_ADDR[ga]);
        end
    endgenerate

    assign wr_hit_top_en   = bus_req.wr && addr_hit[SLOT_TOP_EN];
    assign wr_hit_top_clr  = bus_req.wr && addr_hit[SLOT_TOP_CLR];
    assign wr_hit_ch_en    = bus_req.wr && addr_hit[SLOT_CH_EN];
    assign wr_hit_ch_stop  = bus_req.wr && addr_hit[SLOT_CH_STOP];
    assign wr_hit_base_en  = bus_req.wr && addr_hit[SLOT_BASE_EN];
    assign wr_hit_base_clr = bus_req.wr && addr_hit[SLOT_BASE_CLR];
    assign rd_hit_top_isr  = bus_req.rd && addr_hit[SLOT_TOP_STATUS];
    assign rd_hit_base_isr = bus_req.rd && addr_hit[SLOT_BASE_STATUS];

    // summary follows the masked base flags, so it drops when those are read or their enables are cleared
    assign base_summary = |(s_reg.base_flags & s_reg.base_mask);

    // other layers own their pending levels and clear them on their own reads
    always_comb
    begin
        top_status = s_reg.top_flags & `LBC_TOP_RAW_VALID;
        top_status[`LBC_TOP_BASE_BIT]        = base_summary;
        top_status[`LBC_TOP_OVERLAY_ONE_BIT] = evt.overlay_one_pending;
        top_status[`LBC_TOP_HIGH_END_BIT]    = evt.high_end_overlay_pending;
        top_status[`LBC_TOP_CURSOR_BIT]      = evt.cursor_pending;
    end

    // read mux, unmapped and write-only addresses read zero
    always_comb
    begin
        rd_value = 32'h00000000;
        case (bus_req.addr)
            `LBC_TOP_IRQ_MASK:
            begin
                rd_value[11:0] = s_reg.top_mask;
            end
            `LBC_TOP_IRQ_STATUS:
            begin
                rd_value[11:0] = top_status;
            end
            `LBC_BASE_CH_STATE:
            begin
                rd_value[`LBC_CH_ON_BIT]     = (s_reg.chan != lbc_pkg::LBC_CH_OFF);
                rd_value[`LBC_CH_UPDATE_BIT] = s_reg.update_pend;
                rd_value[`LBC_CH_QUEUE_BIT]  = s_reg.queue_pend;
            end
            `LBC_BASE_IRQ_MASK:
            begin
                rd_value[6:0] = s_reg.base_mask;
            end
            `LBC_BASE_IRQ_STATUS:
            begin
                rd_value[6:0] = s_reg.base_flags;
            end
            default:
            begin
                rd_value = 32'h00000000;
            end
        endcase
    end

    always_comb
    begin
        s_next       = s_reg;
        s_next.apply = 1'b0;
        s_next.abort = 1'b0;
        s_next.rdata = 32'h00000000;
        if (bus_req.rd)
        begin
            s_next.rdata = rd_value;
        end

        // mask and flag bits come from the per-bit slices below
        s_next.top_mask   = top_mask_upd;
        s_next.top_flags  = top_flags_upd;
        s_next.base_mask  = base_mask_upd;
        s_next.base_flags = base_flags_upd;

        // attribute update waits for the next start of frame
        if (s_reg.update_pend && evt.start_of_frame)
        begin
            s_next.update_pend = 1'b0;
            s_next.apply       = 1'b1;
        end
        if (wr_hit_ch_en && bus_req.wdata[`LBC_CH_UPDATE_BIT])
        begin
            s_next.update_pend = 1'b1;
        end

        // head stays requested until the fetch engine reports it absorbed
        if (evt.head_added)
        begin
            s_next.queue_pend = 1'b0;
        end
        if (wr_hit_ch_en && bus_req.wdata[`LBC_CH_QUEUE_BIT])
        begin
            s_next.queue_pend = 1'b1;
        end

        case (s_reg.chan)
            lbc_pkg::LBC_CH_OFF:
            begin
                if (wr_hit_ch_en && bus_req.wdata[`LBC_CH_ON_BIT])
                begin
                    s_next.chan = lbc_pkg::LBC_CH_ON;
                end
            end
            lbc_pkg::LBC_CH_ON:
            begin
                if (wr_hit_ch_stop && bus_req.wdata[`LBC_CH_STOP_BIT])
                begin
                    s_next.chan = lbc_pkg::LBC_CH_STOPPING;
                end
            end
            lbc_pkg::LBC_CH_STOPPING:
            begin
                // a fresh enable cancels the pending stop
                if (wr_hit_ch_en && bus_req.wdata[`LBC_CH_ON_BIT])
                begin
                    s_next.chan = lbc_pkg::LBC_CH_ON;
                end
                else if (evt.frame_done)
                begin
                    s_next.chan = lbc_pkg::LBC_CH_OFF;
                end
            end
            default:
            begin
                s_next.chan = lbc_pkg::LBC_CH_OFF;
            end
        endcase

        // abort overrides everything and drops the queued requests too
        if (wr_hit_ch_stop && bus_req.wdata[`LBC_CH_ABORT_BIT])
        begin
            s_next.chan        = lbc_pkg::LBC_CH_OFF;
            s_next.update_pend = 1'b0;
            s_next.queue_pend  = 1'b0;
            s_next.apply       = 1'b0;
            s_next.abort       = 1'b1;
        end
    end

    // raw top-level events gathered at their flag positions
    // layer summaries are live levels, so they are never latched here
    always_comb
    begin
        top_events                          = 12'h000;
        top_events[`LBC_TOP_SOF_BIT]        = evt.start_of_frame;
        top_events[`LBC_TOP_TIMING_OFF_BIT] = evt.timing_off_done;
        top_events[`LBC_TOP_POWER_SEQ_BIT]  = evt.power_sequence_done;
        top_events[`LBC_TOP_UNDERFLOW_BIT]  = evt.output_underflow;
    end

    // one slice per top-level bit: enable/disable writes on the mask, events on the flag
    genvar gt;
    generate
        for (gt = 0; gt < 12; gt++)
        begin : g_top_bit
            logic mask_set;
            logic mask_clr;
            logic mask_bit;
            logic flag_bit;

            assign mask_set = wr_hit_top_en && bus_req.wdata[gt] && TOP_VALID[gt];
            assign mask_clr = wr_hit_top_clr && bus_req.wdata[gt] && TOP_VALID[gt];

            // enable and disable sit at different addresses, so they never meet
            always_comb
            begin
                mask_bit = s_reg.top_mask[gt];
                if (mask_set)
                begin
                    mask_bit = 1'b1;
                end
                if (mask_clr)
                begin
                    mask_bit = 1'b0;
                end
            end

            // clear on read first, then the event, so a same-cycle event is not lost
            always_comb
            begin
                flag_bit = s_reg.top_flags[gt];
                if (rd_hit_top_isr)
                begin
                    flag_bit = 1'b0;
                end
                if (top_events[gt] && TOP_RAW_VALID[gt])
                begin
                    flag_bit = 1'b1;
                end
            end

            assign top_mask_upd[gt]  = mask_bit;
            assign top_flags_upd[gt] = flag_bit;
        end
    endgenerate

    // one slice per base-layer source; bits 0 and 1 have no source and stay zero
    genvar gb;
    generate
        for (gb = 0; gb < 7; gb++)
        begin : g_base_bit
            logic mask_set;
            logic mask_clr;
            logic mask_bit;
            logic flag_bit;

            assign mask_set = wr_hit_base_en && bus_req.wdata[gb] && BASE_VALID[gb];
            assign mask_clr = wr_hit_base_clr && bus_req.wdata[gb] && BASE_VALID[gb];

            // ones act and zeros leave the source alone
            always_comb
            begin
                mask_bit = s_reg.base_mask[gb];
                if (mask_set)
                begin
                    mask_bit = 1'b1;
                end
                if (mask_clr)
                begin
                    mask_bit = 1'b0;
                end
            end

            // the set wins over clear-on-read
            always_comb
            begin
                flag_bit = s_reg.base_flags[gb];
                if (rd_hit_base_isr)
                begin
                    flag_bit = 1'b0;
                end
                if (evt.base_source[gb] && BASE_VALID[gb])
                begin
                    flag_bit = 1'b1;
                end
            end

            assign base_mask_upd[gb]  = mask_bit;
            assign base_flags_upd[gb] = flag_bit;
        end
    endgenerate

    // the asynchronous reset loads constants only
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_reg.chan        <= lbc_pkg::LBC_CH_OFF;
            s_reg.update_pend <= 1'b0;
            s_reg.queue_pend  <= 1'b0;
            s_reg.top_mask    <= `LBC_TOP_MASK_RESET;
            s_reg.top_flags   <= `LBC_TOP_FLAGS_RESET;
            s_reg.base_mask   <= `LBC_BASE_MASK_RESET;
            s_reg.base_flags  <= `LBC_BASE_FLAGS_RESET;
            s_reg.apply       <= 1'b0;
            s_reg.abort       <= 1'b0;
            s_reg.rdata       <= 32'h00000000;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign rd_data            = s_reg.rdata;
    assign channel_on         = (s_reg.chan != lbc_pkg::LBC_CH_OFF);
    assign attribute_apply    = s_reg.apply;
    assign head_queue_request = s_reg.queue_pend;
    assign channel_abort      = s_reg.abort;
    assign irq                = |(top_status & s_reg.top_mask);

endmodule

// ==== verification/lbc_monitor.sv ====
// assertion checker for the irq / base channel register bank
`timescale 1ns/1ns
`include "lbc_defs.svh"
module lbc_monitor
(
    // clock and reset
    input wire logic              clk,
    input wire logic              nrst,
    // watched ports
    input wire lbc_pkg::lbc_req_s bus_req,
    input wire lbc_pkg::lbc_evt_s evt,
    input wire logic [31:0]       rd_data,
    input wire logic              channel_on,
    input wire logic              attribute_apply,
    input wire logic              head_queue_request,
    input wire logic              channel_abort
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_wr(a, b);
        bus_req.wr && bus_req.addr == a && bus_req.wdata[b];
    endsequence
    sequence s_rd(a);
        bus_req.rd && bus_req.addr == a;
    endsequence
    chk_rdata_idle: assert property (
        !bus_req.rd |=> rd_data == 32'h0) else $error("read data outside a read");
    chk_wo_read: assert property (
        s_rd(`LBC_BASE_CH_ENABLE) |=> rd_data == 32'h0) else $error("write-only reads");
    chk_state_read: assert property (
        s_rd(`LBC_BASE_CH_STATE) |=> rd_data[0] == $past(channel_on)
        && rd_data[2] == $past(head_queue_request)) else $error("state read wrong");
    chk_enable_on: assert property (
        s_wr(`LBC_BASE_CH_ENABLE, 0) |=> channel_on) else $error("enable ignored");
    chk_stop_waits: assert property (
        s_wr(`LBC_BASE_CH_DISABLE, 0) ##0 (!bus_req.wdata[8] && !evt.frame_done)
        |=> channel_on == $past(channel_on)) else $error("stop before frame end");
    chk_abort_now: assert property (
        s_wr(`LBC_BASE_CH_DISABLE, 8) |=> channel_abort && !channel_on)
        else $error("abort late");
    chk_queue_set: assert property (
        s_wr(`LBC_BASE_CH_ENABLE, 2) |=> head_queue_request) else $error("queue not set");
    chk_queue_drop: assert property (
        head_queue_request && evt.head_added && !bus_req.wr |=> !head_queue_request)
        else $error("queue not cleared");
    chk_apply_sof: assert property (
        attribute_apply |-> $past(evt.start_of_frame)) else $error("apply off frame");
endmodule
bind lbc_top lbc_monitor i_monitor (.clk(clk), .nrst(nrst), .bus_req(bus_req), .evt(evt),
    .rd_data(rd_data), .channel_on(channel_on), .attribute_apply(attribute_apply),
    .head_queue_request(head_queue_request), .channel_abort(channel_abort));

// ==== verification/tb.sv ====
// self-checking bench for the irq / base channel register bank
`timescale 1ns/1ns
`include "lbc_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module tb;
    logic              clk;
    logic              nrst;
    lbc_pkg::lbc_req_s req;
    lbc_pkg::lbc_evt_s ev;
    lbc_pkg::lbc_evt_s p;
    lbc_pkg::lbc_evt_s evt;
    logic [2:0]        lay;
    logic [31:0]       rd_data;
    logic              ch_on;
    logic              apply;
    logic              hq;
    logic              abort;
    logic              irq;
    int                failures = 0;
    int                checked = 0;
    int                cycles = 0;
    lbc_top i_dut (.clk(clk), .nrst(nrst), .bus_req(req), .rd_data(rd_data), .evt(evt),
        .channel_on(ch_on), .attribute_apply(apply), .head_queue_request(hq),
        .channel_abort(abort), .irq(irq));
    always_comb
    begin
        evt = ev;
        {evt.cursor_pending, evt.high_end_overlay_pending, evt.overlay_one_pending} = lay;
    end
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            conclude();
        end
    end
    task automatic conclude;
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
        @(posedge clk);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        `CHK(n, e, rd_data)
    endtask
    // engine events last exactly one cycle
    task automatic pulse;
        @(posedge clk);
        ev <= p;
        p = '0;
        @(posedge clk);
        ev <= '0;
        #1;
    endtask
    task automatic t_reset;
        rd(`LBC_TOP_IRQ_MASK, 32'h0, "top mask");
        rd(`LBC_TOP_IRQ_STATUS, 32'h0, "top status");
        rd(`LBC_BASE_IRQ_MASK, 32'h0, "base mask");
        rd(`LBC_BASE_CH_STATE, 32'h0, "state");
        rd(32'hf803803c, 32'h0, "unmapped");
        `CHK("irq", 1'b0, irq)
    endtask
    task automatic t_top;
        wr(`LBC_TOP_IRQ_ENABLE, 32'hf17);
        rd(`LBC_TOP_IRQ_MASK, 32'hf17, "top mask");
        wr(`LBC_TOP_IRQ_DISABLE, 32'hf00);
        rd(`LBC_TOP_IRQ_MASK, 32'h017, "top mask");
        p.output_underflow = 1'b1;
        pulse();
        `CHK("irq", 1'b1, irq)
        p.start_of_frame = 1'b1;
        p.timing_off_done = 1'b1;
        p.power_sequence_done = 1'b1;
        pulse();
        rd(`LBC_TOP_IRQ_STATUS, 32'h17, "top status");
        rd(`LBC_TOP_IRQ_STATUS, 32'h0, "top status");
        `CHK("irq", 1'b0, irq)
        @(posedge clk) lay <= 3'b111;
        rd(`LBC_TOP_IRQ_STATUS, 32'he00, "layers");
        rd(`LBC_TOP_IRQ_STATUS, 32'he00, "layers");
        wr(`LBC_TOP_IRQ_ENABLE, 32'h200);
        `CHK("irq", 1'b1, irq)
        wr(`LBC_TOP_IRQ_DISABLE, 32'h200);
        @(posedge clk) lay <= 3'b000;
        rd(`LBC_TOP_IRQ_STATUS, 32'h0, "layers");
    endtask
    task automatic t_base;
        wr(`LBC_TOP_IRQ_ENABLE, 32'h100);
        wr(`LBC_BASE_IRQ_ENABLE, 32'h7c);
        wr(`LBC_BASE_IRQ_ENABLE, 32'h0);
        rd(`LBC_BASE_IRQ_MASK, 32'h7c, "base mask");
        wr(`LBC_BASE_IRQ_DISABLE, 32'h44);
        wr(`LBC_BASE_IRQ_DISABLE, 32'h0);
        rd(`LBC_BASE_IRQ_MASK, 32'h38, "base mask");
        p.base_source = 7'h44;
        pulse();
        rd(`LBC_TOP_IRQ_STATUS, 32'h0, "masked base");
        p.base_source = 7'h7f;
        pulse();
        rd(`LBC_TOP_IRQ_STATUS, 32'h100, "base sum");
        rd(`LBC_TOP_IRQ_STATUS, 32'h100, "base sum");
        `CHK("irq", 1'b1, irq)
        rd(`LBC_BASE_IRQ_STATUS, 32'h7c, "base status");
        rd(`LBC_BASE_IRQ_STATUS, 32'h0, "base status");
        rd(`LBC_TOP_IRQ_STATUS, 32'h0, "base sum");
    endtask
    task automatic t_channel;
        wr(`LBC_BASE_CH_DISABLE, 32'h1);
        wr(`LBC_BASE_CH_ENABLE, 32'h0);
        `CHK("on", 1'b0, ch_on)
        wr(`LBC_BASE_CH_ENABLE, 32'h1);
        rd(`LBC_BASE_CH_ENABLE, 32'h0, "write only");
        wr(`LBC_BASE_CH_ENABLE, 32'h6);
        rd(`LBC_BASE_CH_STATE, 32'h7, "state");
        p.head_added = 1'b1;
        pulse();
        `CHK("queue", 1'b0, hq)
        p.start_of_frame = 1'b1;
        pulse();
        `CHK("apply", 1'b1, apply)
        rd(`LBC_BASE_CH_STATE, 32'h1, "state");
        wr(`LBC_BASE_CH_DISABLE, 32'h1);
        repeat (4) @(posedge clk);
        `CHK("on", 1'b1, ch_on)
        p.frame_done = 1'b1;
        pulse();
        `CHK("on", 1'b0, ch_on)
        wr(`LBC_BASE_CH_ENABLE, 32'h3);
        wr(`LBC_BASE_CH_DISABLE, 32'h100);
        `CHK("abort", 1'b1, abort)
        rd(`LBC_BASE_CH_STATE, 32'h0, "state");
    endtask
    initial
    begin
        nrst = 1'b0;
        req = '0;
        ev = '0;
        p = '0;
        lay = 3'b000;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_top();
        t_base();
        t_channel();
        conclude();
    end
endmodule
